// >>> inc/bstc_pkg.sv
package bstc_pkg;
  // Default geometry of the array behind the pins
  localparam int ADDR_W_DEF = 8;
  localparam int DATA_W_DEF = 16;
  // Width of the read latency setting and of the burst length code
  localparam int LAT_W = 3;
  localparam int BLC_W = 3;
  // Burst length is 8 words shifted left by the code, code 0 to 4
  localparam int BL_BASE_LOG = 3;
  localparam logic [BLC_W-1:0] BL_CODE_MAX = 3'h4;
  // Write latency is the read latency less this many cycles
  localparam logic [LAT_W-1:0] WR_LAT_OFFSET = 3'h1;
  // Shortest latency the latency counter supports
  localparam logic [LAT_W-1:0] LAT_MIN = 3'h2;
  // Log2 of the depth of the word buffer toward the system side
  localparam int BUF_AW_DEF = 1;
endpackage

// >>> hw/bstc_burst_ctrl.sv
module bstc_burst_ctrl #(
  parameter int ADDR_W = bstc_pkg::ADDR_W_DEF,
  parameter int DATA_W = bstc_pkg::DATA_W_DEF,
  parameter int BUF_AW = bstc_pkg::BUF_AW_DEF
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        memClk,
  input  wire logic                        chip_select_primary_n,
  input  wire logic                        chip_select_power_keep,
  input  wire logic                        address_latch_strobe_n,
  input  wire logic                        writeStrobeN,
  input  wire logic                        outputEnableN,
  input  wire logic [ADDR_W-1:0]           addrIn,
  input  wire logic [DATA_W-1:0]           dqIn,
  output logic      [DATA_W-1:0]           dqOut,
  output logic                             dqOeN,
  output logic                             waitOut,
  output logic                             waitOeN,
  input  wire logic                        levelWriteMode,
  input  wire logic [bstc_pkg::LAT_W-1:0]  read_latency_setting,
  input  wire logic [bstc_pkg::BLC_W-1:0]  burst_word_count,
  output logic                             wordValid,
  output logic      [ADDR_W-1:0]           wordAddr,
  output logic      [DATA_W-1:0]           wordData,
  input  wire logic                        wordReady
);
  import bstc_pkg::*;

  localparam int WORD_W = ADDR_W + DATA_W;
  localparam int DEPTH  = 1 << BUF_AW;

  typedef enum logic [2:0] {L_IDLE, L_LAT, L_WR, L_RD, L_END} bstc_link_e;

  function automatic logic [BUF_AW:0] grayToBin(input logic [BUF_AW:0] g);
    logic [BUF_AW:0] b;
    b = '0;
    b[BUF_AW] = g[BUF_AW];
    for (int i = BUF_AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Link-domain reset and configuration, each through two flops
  logic              lnkRstMeta_q;
  logic              lnkRst_q;
  logic              levelMeta_q;
  logic              level_q;
  logic              keepMeta_q;
  logic              keep_q;
  logic [LAT_W-1:0]  latMeta_q;
  logic [LAT_W-1:0]  lat_q;
  logic [BLC_W-1:0]  blMeta_q;
  logic [BLC_W-1:0]  bl_q;

  always_ff @(posedge memClk) begin
    lnkRstMeta_q <= rst;
    lnkRst_q     <= lnkRstMeta_q;
  end

  // Configuration is meant to be static while a burst runs
  always_ff @(posedge memClk) begin
    levelMeta_q <= levelWriteMode;
    level_q     <= levelMeta_q;
    keepMeta_q  <= chip_select_power_keep;
    keep_q      <= keepMeta_q;
    latMeta_q   <= read_latency_setting;
    lat_q       <= latMeta_q;
    blMeta_q    <= burst_word_count;
    bl_q        <= blMeta_q;
  end

  // Link-side state
  bstc_link_e        state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [LAT_W-1:0]  latCnt_q;
  logic [7:0]        beatsLeft_q;
  logic              isWr_q;
  logic              firstBeat_q;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Word buffer toward the system side
  logic [WORD_W-1:0] bufMem [0:DEPTH-1];
  logic [BUF_AW:0]   wrBin_q;
  logic [BUF_AW:0]   wrGray_q;
  logic [BUF_AW:0]   rdGrayMeta_q;
  logic [BUF_AW:0]   rdGraySync_q;
  logic [BUF_AW:0]   rdBin_q;
  logic [BUF_AW:0]   rdGray_q;
  logic [BUF_AW:0]   wrGrayMeta_q;
  logic [BUF_AW:0]   wrGraySync_q;

  logic              selected;
  logic              latchNow;
  logic              wantWr;
  logic [LAT_W-1:0]  latTgt;
  logic [LAT_W-1:0]  latUse;
  logic [7:0]        blLen;
  logic [ADDR_W-1:0] wrapMask;
  logic [ADDR_W-1:0] addrNext;
  logic              bufFull;
  logic              beatOk;
  logic              doWrite;
  logic [BUF_AW:0]   fillLevel;
  logic [BUF_AW:0]   wrBinNext;

  always_comb begin
    selected = !chip_select_primary_n && keep_q;
    latchNow = selected && !address_latch_strobe_n;
    // Level mode may latch with the strobe high; output enable high then marks a write
    wantWr   = !writeStrobeN || (level_q && outputEnableN);
    latUse   = (lat_q < LAT_MIN) ? LAT_MIN : lat_q;
    latTgt   = isWr_q ? latUse - WR_LAT_OFFSET : latUse;
    blLen    = 8'(1 << (BL_BASE_LOG + int'((bl_q > BL_CODE_MAX) ? BL_CODE_MAX : bl_q)));
    wrapMask = ADDR_W'(blLen - 8'h01);
    addrNext = (addr_q & ~wrapMask) | ((addr_q + 1'b1) & wrapMask);
    fillLevel = wrBin_q - grayToBin(rdGraySync_q);
    bufFull  = (fillLevel == (BUF_AW+1)'(DEPTH));
    // First beat is never suspended; single-pulse mode ignores the strobe level
    beatOk   = firstBeat_q || !level_q || !writeStrobeN;
    doWrite  = selected && !lnkRst_q && (state_q == L_WR) && beatOk && !bufFull;
    wrBinNext = wrBin_q + 1'b1;
  end

  // Burst sequencer
  always_ff @(posedge memClk) begin
    if (lnkRst_q || !selected) begin
      // Deselect drops remaining beats and releases the pins
      state_q     <= L_IDLE;
      addr_q      <= '0;
      latCnt_q    <= '0;
      beatsLeft_q <= '0;
      isWr_q      <= 1'b0;
      firstBeat_q <= 1'b0;
      dqOut       <= '0;
      dqOeN       <= 1'b1;
      waitOut     <= 1'b0;
      waitOeN     <= 1'b1;
    end else begin
      case (state_q)
        L_IDLE: begin
          waitOeN <= 1'b0;
          waitOut <= 1'b0;
          if (latchNow) begin
            addr_q      <= addrIn;
            isWr_q      <= wantWr;
            firstBeat_q <= 1'b1;
            latCnt_q    <= LAT_W'(1);
            beatsLeft_q <= blLen - 8'h01;
            state_q     <= L_LAT;
            // Shortest write latency leaves no cycle for the latency count
            if (wantWr && (latUse - WR_LAT_OFFSET) <= LAT_W'(1)) begin
              waitOut <= 1'b1;
              state_q <= L_WR;
            end
          end
        end
        L_LAT: begin
          latCnt_q <= latCnt_q + 1'b1;
          if (latCnt_q + 1'b1 >= latTgt) begin
            waitOut <= 1'b1;
          end
          if (latCnt_q + 1'b1 >= latTgt && isWr_q) begin
            state_q <= L_WR;
          end else if (latCnt_q + 1'b1 >= latTgt) begin
            dqOut       <= mem[addr_q];
            dqOeN       <= outputEnableN;
            addr_q      <= addrNext;
            state_q     <= L_RD;
          end
        end
        L_WR: begin
          // A suspended or stalled beat holds the counter and the address, with wait kept high
          waitOut <= 1'b1;
          if (doWrite) begin
            firstBeat_q <= 1'b0;
            addr_q      <= addrNext;
            beatsLeft_q <= beatsLeft_q - 8'h01;
            if (beatsLeft_q == 8'h00) begin
              state_q <= L_END;
            end
          end
        end
        L_RD: begin
          if (beatsLeft_q == 8'h00) begin
            dqOeN   <= 1'b1;
            state_q <= L_END;
          end else begin
            dqOut       <= mem[addr_q];
            dqOeN       <= outputEnableN;
            addr_q      <= addrNext;
            beatsLeft_q <= beatsLeft_q - 8'h01;
          end
        end
        L_END: begin
          // Stays here until deselect so a held latch strobe cannot restart
          dqOeN <= 1'b1;
        end
        default: begin
          state_q <= L_IDLE;
        end
      endcase
    end
  end

  // Array write on accepted beats only
  always_ff @(posedge memClk) begin
    if (doWrite) begin
      mem[addr_q] <= dqIn;
    end
  end

  // Buffer fill side on the link clock
  always_ff @(posedge memClk) begin
    if (doWrite) begin
      bufMem[wrBin_q[BUF_AW-1:0]] <= {addr_q, dqIn};
    end
  end

  always_ff @(posedge memClk) begin
    if (lnkRst_q) begin
      wrBin_q  <= '0;
      wrGray_q <= '0;
    end else if (doWrite) begin
      wrBin_q  <= wrBinNext;
      wrGray_q <= wrBinNext ^ (wrBinNext >> 1);
    end
  end

  always_ff @(posedge memClk) begin
    if (lnkRst_q) begin
      rdGrayMeta_q <= '0;
      rdGraySync_q <= '0;
    end else begin
      rdGrayMeta_q <= rdGray_q;
      rdGraySync_q <= rdGrayMeta_q;
    end
  end

  // Buffer drain side on the system clock
  logic            bufEmpty;
  logic            popNow;
  logic [BUF_AW:0] rdBinNext;

  always_comb begin
    bufEmpty  = (rdGray_q == wrGraySync_q);
    popNow    = !bufEmpty && (!wordValid || wordReady);
    rdBinNext = rdBin_q + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrGrayMeta_q <= '0;
      wrGraySync_q <= '0;
    end else begin
      wrGrayMeta_q <= wrGray_q;
      wrGraySync_q <= wrGrayMeta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdBin_q  <= '0;
      rdGray_q <= '0;
    end else if (popNow) begin
      rdBin_q  <= rdBinNext;
      rdGray_q <= rdBinNext ^ (rdBinNext >> 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wordValid <= 1'b0;
      wordAddr  <= '0;
      wordData  <= '0;
    end else if (popNow) begin
      wordValid <= 1'b1;
      {wordAddr, wordData} <= bufMem[rdBin_q[BUF_AW-1:0]];
    end else if (wordReady) begin
      wordValid <= 1'b0;
    end
  end

endmodule

// >>> verification/bstc_burst_sva.sv
module bstc_burst_sva #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              memClk,
  input wire logic              chip_select_primary_n,
  input wire logic              address_latch_strobe_n,
  input wire logic              writeStrobeN,
  input wire logic              outputEnableN,
  input wire logic [2:0]        read_latency_setting,
  input wire logic              dqOeN,
  input wire logic              waitOut,
  input wire logic              waitOeN,
  input wire logic              wordValid,
  input wire logic [ADDR_W-1:0] wordAddr,
  input wire logic [DATA_W-1:0] wordData,
  input wire logic              wordReady
);
  logic latchRd;
  logic latchWr;
  // Idle waitOeN keeps a stray strobe inside a burst from counting as a latch
  assign latchRd = !chip_select_primary_n && !address_latch_strobe_n && waitOeN && writeStrobeN && !outputEnableN;
  assign latchWr = !chip_select_primary_n && !address_latch_strobe_n && waitOeN && !writeStrobeN;
  write_latency_a: assert property (@(posedge memClk) disable iff (rst)
    latchWr && read_latency_setting == 3'h3 |-> ##1 !waitOut ##1 waitOut) else $error("write wait edge off");
  abort_release_a: assert property (@(posedge memClk) disable iff (rst)
    chip_select_primary_n |=> dqOeN && waitOeN) else $error("late release");
  read_latency_a: assert property (@(posedge memClk) disable iff (rst)
    latchRd && read_latency_setting == 3'h3 |-> ##2 !waitOut ##1 waitOut) else $error("wait edge off");
  wait_hold_a: assert property (@(posedge memClk) disable iff (rst)
    waitOut && !chip_select_primary_n ##1 !chip_select_primary_n |-> waitOut) else $error("wait dropped");
  wait_enable_a: assert property (@(posedge memClk) disable iff (rst)
    $rose(waitOut) |-> !waitOeN) else $error("wait high while released");
  drive_gate_a: assert property (@(posedge memClk) disable iff (rst)
    !dqOeN |-> !waitOeN) else $error("data driven while deselected");
  release_cause_a: assert property (@(posedge memClk) disable iff (rst)
    $rose(waitOeN) |-> $past(chip_select_primary_n)) else $error("release without deselect");
  word_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    wordValid && !wordReady |=> wordValid && $stable(wordAddr) && $stable(wordData)) else $error("word moved");
  word_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(wordValid) |-> $past(wordReady)) else $error("word lost");
  read_c: cover property (@(posedge memClk) latchRd);
  susp_c: cover property (@(posedge memClk) !chip_select_primary_n && writeStrobeN && waitOut && outputEnableN);
  stall_c: cover property (@(posedge sys_clk) wordValid && !wordReady);
endmodule

// >>> verification/bstc_host_model.sv
module bstc_host_model (
  output logic       memClk,
  output logic       chip_select_primary_n,
  output logic       address_latch_strobe_n,
  output logic       writeStrobeN,
  output logic       outputEnableN,
  output logic [7:0] addrIn,
  output logic [15:0] dqIn,
  input wire logic [15:0] dqOut,
  input wire logic        dqOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        run = 1'b0;
  logic [15:0] rdBuf [8];
  // Clock stands low between frames, as a host clock gate would leave it
  initial begin
    {memClk, addrIn, dqIn} = '0;
    {chip_select_primary_n, address_latch_strobe_n, writeStrobeN, outputEnableN} = 4'hf;
    #7;
    forever #16 memClk = run & ~memClk;
  end
  task automatic tick(input int n);
    run = 1'b1;
    repeat (n) @(negedge memClk);
    run = 1'b0;
  endtask
  task automatic stop();
    chip_select_primary_n = 1'b1;
    writeStrobeN = 1'b1;
    outputEnableN = 1'b1;
    dqIn = ~dqIn;
    addrIn = ~addrIn;
    tick(4);
  endtask
  task automatic start(input logic [7:0] a);
    tick(3);
    run = 1'b1;
    chip_select_primary_n = 1'b0;
    address_latch_strobe_n = 1'b0;
    addrIn = a;
    @(negedge memClk);
    address_latch_strobe_n = 1'b1;
    addrIn = ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic weLatch, input int susp, input int n);
    writeStrobeN = weLatch;
    dqIn = ~d;
    start(a);
    @(negedge memClk);
    writeStrobeN = 1'b0;
    dqIn = d;
    for (int i = 0; i < n; i++) begin
      @(negedge memClk);
      writeStrobeN = (i < susp);
      dqIn = (i < susp) ? ~d : d;
    end
    @(negedge memClk);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    outputEnableN = 1'b0;
    start(a);
    repeat (2) @(negedge memClk);
    for (int i = 0; i < n; i++) begin
      // A released bus shows the inverse so an undriven beat cannot pass
      rdBuf[i] = dqOeN ? ~dqOut : dqOut;
      @(negedge memClk);
    end
    stop();
  endtask
endmodule

// >>> verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        levelWriteMode = 1'b1;
  logic        wordReady = 1'b0;
  logic        memClk, chip_select_primary_n, address_latch_strobe_n, writeStrobeN, outputEnableN;
  logic        dqOeN, waitOut, waitOeN, wordValid;
  logic [7:0]  addrIn, wordAddr;
  logic [15:0] dqIn, dqOut, wordData;
  logic [7:0]  gotA [$];
  logic [15:0] gotD [$];
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #50 sys_clk = ~sys_clk;
  bstc_burst_ctrl bstc_burst_ctrl_inst (
    .sys_clk, .rst, .memClk, .chip_select_primary_n, .chip_select_power_keep(1'b1), .address_latch_strobe_n,
    .writeStrobeN, .outputEnableN, .addrIn, .dqIn, .dqOut, .dqOeN, .waitOut, .waitOeN, .levelWriteMode,
    .read_latency_setting(3'h3), .burst_word_count(3'h0), .wordValid, .wordAddr, .wordData, .wordReady
  );
  bstc_host_model bstc_host_model_inst (
    .memClk, .chip_select_primary_n, .address_latch_strobe_n, .writeStrobeN, .outputEnableN, .addrIn, .dqIn, .dqOut,
    .dqOeN
  );
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1500) begin
      n_errors++;
      complete_run();
    end
    if (wordValid === 1'b1 && wordReady === 1'b1) begin
      gotA.push_back(wordAddr);
      gotD.push_back(wordData);
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Words must climb from the latched address and wrap inside the 8-word block
  task automatic chk_words(input logic [7:0] a, input int n, input logic [15:0] d);
    chk("word count", 16'(n), 16'(gotA.size()));
    foreach (gotA[i]) begin
      chk("word addr", {8'h00, a[7:3], 3'(a[2:0] + i)}, {8'h00, gotA[i]});
      if (d != 16'h0000) chk("word data", d, gotD[i]);
    end
    gotA.delete();
    gotD.delete();
  endtask
  task automatic test_level_write();
    @(negedge sys_clk);
    wordReady = 1'b0;
    fork
      bstc_host_model_inst.wr(8'h10, 16'h1111, 1'b1, 6, 80);
      begin
        repeat (10) @(negedge sys_clk);
        wordReady = 1'b1;
      end
    join
    repeat (30) @(negedge sys_clk);
    chk_words(8'h10, 8, 16'h1111);
  endtask
  task automatic test_pulse_write();
    int junk;
    junk = 0;
    @(negedge sys_clk);
    levelWriteMode = 1'b0;
    bstc_host_model_inst.wr(8'h18, 16'h2222, 1'b0, 12, 60);
    repeat (30) @(negedge sys_clk);
    foreach (gotD[i]) if (gotD[i] === 16'hdddd) junk++;
    chk("pulse junk", 16'h1, 16'(junk > 0));
    chk_words(8'h18, 8, 16'h0000);
  endtask
  task automatic test_write_abort();
    @(negedge sys_clk);
    levelWriteMode = 1'b1;
    wordReady = 1'b0;
    bstc_host_model_inst.wr(8'h20, 16'h3333, 1'b0, 0, 3);
    chk("abort release", 16'h3, 16'({dqOeN, waitOeN}));
    @(negedge sys_clk);
    wordReady = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk_words(8'h20, 2, 16'h3333);
  endtask
  task automatic test_read();
    bstc_host_model_inst.rd(8'h13, 8);
    for (int i = 0; i < 8; i++) chk("read beat", 16'h1111, bstc_host_model_inst.rdBuf[i]);
    bstc_host_model_inst.rd(8'h15, 2);
    chk("read release", 16'h3, 16'({dqOeN, waitOeN}));
    chk("abort beat", 16'h1111, bstc_host_model_inst.rdBuf[1]);
  endtask
  initial begin
    fork
      bstc_host_model_inst.tick(8);
      repeat (10) @(negedge sys_clk);
    join
    rst = 1'b0;
    bstc_host_model_inst.tick(4);
    chk("reset outputs", 16'h3, 16'({dqOeN, waitOeN}));
    chk("reset word", 16'h0, 16'(wordValid));
    test_level_write();
    test_pulse_write();
    test_write_abort();
    test_read();
    complete_run();
  end
endmodule
bind bstc_burst_ctrl bstc_burst_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) bstc_burst_sva_inst (
  .sys_clk, .rst, .memClk, .chip_select_primary_n, .address_latch_strobe_n, .writeStrobeN, .outputEnableN,
  .read_latency_setting, .dqOeN, .waitOut, .waitOeN, .wordValid, .wordAddr, .wordData, .wordReady
);
